// file: design/clkout_and_temp_ref_calib_config.sv
/*
 * clock-output source/frequency selection and temperature-reference mirror.
 * assumes: a byte register port from the device's serial front end, a
 * non-volatile store read port with one-cycle latency, tick inputs from the
 * prescaler chain and synthesizer on this clock, and an unlock level from
 * the password logic. the external event pin is asynchronous.
 */
`timescale 1ns/100ps
module clkout_and_temp_ref_calib_config
    import clkout_cfg_pkg::*;
#(
    parameter int REFRESH_CNT = REFRESH_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    input wire logic write_unlocked,
    output logic [7:0] nv_addr,
    output logic nv_rd,
    input wire logic [7:0] nv_rdata,
    output logic mirrors_valid,
    input wire logic tick_32k,
    input wire logic comp_pulse,
    input wire logic hf_clock_in,
    input wire logic seconds_write,
    input wire logic event_sync_enable,
    input wire logic external_event_input,
    input wire logic stop_timekeeping,
    input wire logic square_wave_disable_n,
    input wire logic clk_int_request,
    input wire logic signed [15:0] temp_raw,
    output logic signed [15:0] temp_calibrated,
    output logic [31:0] stored_passcode,
    output clkout_cfg_type clkout_cfg,
    output logic clkout_pin
);

    // whole state of the block
    typedef struct packed {
        refresh_state_type fsm;
        logic [31:0] wait_cnt;
        logic [3:0] copy_idx;
        logic copy_pend;
        logic [7:0] sel_low;
        logic [7:0] sel_high;
        logic [15:0] temp_ref_calib;
        logic [31:0] pass;
        logic [13:0] div_cnt; // wide enough for the 1 Hz half period
        logic div_out;
        logic evt_prev;
        logic [15:0] temp_cal;
        logic pin;
        logic [7:0] rdata;
    } cfg_state_type;

    cfg_state_type st_r;
    cfg_state_type st_nxt;
    logic evt_level;       // qualified event pin level
    logic evt_edge;        // rising edge of the qualified level
    logic restart_low;     // restart of the low-frequency divider
    logic out_enable;      // square wave allowed onto the pin
    logic low_stopped;     // low crystal outputs frozen
    logic wr_ok;           // register write accepted

    // event pin is asynchronous, so it is conditioned first
    pin_sync3 u_evt_sync
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in(external_event_input),
        .level_out(evt_level)
    );

    assign evt_edge = evt_level & ~st_r.evt_prev;
    assign restart_low = seconds_write | (evt_edge & event_sync_enable);
    assign out_enable = ~square_wave_disable_n | clk_int_request;
    // stop only touches crystal codes other than 32 kHz
    assign low_stopped = stop_timekeeping & ~st_r.sel_high[POS_OSC_SRC]
        & (st_r.sel_high[POS_XTAL_SEL_HI:POS_XTAL_SEL_LO] != XSEL_32K);
    assign wr_ok = reg_req.wr & write_unlocked;

    // next-state logic: refresh copy, register writes, divider, pin select
    always_comb
    begin
        logic [13:0] half;
        half = 14'h0000;
        st_nxt = st_r;
        st_nxt.copy_pend = 1'b0;
        st_nxt.evt_prev = evt_level;

        // power-up refresh: wait, then read one store byte per cycle
        unique case (st_r.fsm)
            ST_WAIT:
            begin
                if (st_r.wait_cnt >= 32'(REFRESH_CNT - 1))
                begin
                    st_nxt.fsm = ST_COPY;
                    st_nxt.copy_idx = 4'h0;
                    st_nxt.copy_pend = 1'b1;
                end
                else
                begin
                    st_nxt.wait_cnt = st_r.wait_cnt + 32'h0000_0001;
                end
            end
            ST_COPY:
            begin
                // data for copy_idx arrives this cycle
                unique case (st_r.copy_idx)
                    4'h0: st_nxt.sel_low = nv_rdata;
                    4'h1: st_nxt.sel_high = nv_rdata;
                    4'h2: st_nxt.temp_ref_calib[7:0] = nv_rdata;
                    4'h3: st_nxt.temp_ref_calib[15:8] = nv_rdata;
                    4'h4: st_nxt.pass[7:0] = nv_rdata;
                    4'h5: st_nxt.pass[15:8] = nv_rdata;
                    4'h6: st_nxt.pass[23:16] = nv_rdata;
                    default: st_nxt.pass[31:24] = nv_rdata;
                endcase
                if (st_r.copy_idx == 4'(3 + NUM_PASS_BYTES))
                begin
                    st_nxt.fsm = ST_DONE;
                end
                else
                begin
                    st_nxt.copy_idx = st_r.copy_idx + 4'h1;
                    st_nxt.copy_pend = 1'b1;
                end
            end
            ST_DONE:
            begin
                // user writes, only once the mirrors are loaded
                if (wr_ok)
                begin
                    unique case (reg_req.addr)
                        OFS_CLKOUT_SEL_LOW: st_nxt.sel_low = reg_req.wdata;
                        OFS_CLKOUT_SEL_HIGH: st_nxt.sel_high = reg_req.wdata;
                        OFS_TEMP_REF_CALIB_LOW: st_nxt.temp_ref_calib[7:0] = reg_req.wdata;
                        OFS_TEMP_REF_CALIB_HIGH: st_nxt.temp_ref_calib[15:8] = reg_req.wdata;
                        default: ;
                    endcase
                end
            end
            default: st_nxt.fsm = ST_WAIT;
        endcase

        // reads always allowed; unmapped and passcode read as zero
        unique case (reg_req.addr)
            OFS_CLKOUT_SEL_LOW: st_nxt.rdata = st_r.sel_low;
            OFS_CLKOUT_SEL_HIGH: st_nxt.rdata = st_r.sel_high;
            OFS_TEMP_REF_CALIB_LOW: st_nxt.rdata = st_r.temp_ref_calib[7:0];
            OFS_TEMP_REF_CALIB_HIGH: st_nxt.rdata = st_r.temp_ref_calib[15:8];
            default: st_nxt.rdata = 8'h00;
        endcase

        // low-frequency divider from the 32 kHz tick; compensation pulses
        // add a tick, which may shorten one output period
        unique case (st_r.sel_high[POS_XTAL_SEL_HI:POS_XTAL_SEL_LO])
            XSEL_1024: half = HALF_1024HZ;
            XSEL_64: half = HALF_64HZ;
            // 32 kHz never reads the divider, so it shares the 1 Hz count
            default: half = HALF_1HZ;
        endcase
        if (restart_low)
        begin
            st_nxt.div_cnt = 14'h0000;
            st_nxt.div_out = 1'b0;
        end
        else if (!low_stopped && (tick_32k || comp_pulse))
        begin
            if (st_r.div_cnt >= half)
            begin
                st_nxt.div_cnt = 14'h0000;
                st_nxt.div_out = ~st_r.div_out;
            end
            else
            begin
                st_nxt.div_cnt = st_r.div_cnt + 14'h0001;
            end
        end

        // pin source: synthesizer path bypasses divider and compensation
        if (!out_enable)
        begin
            st_nxt.pin = 1'b0;
        end
        else if (st_r.sel_high[POS_OSC_SRC])
        begin
            st_nxt.pin = hf_clock_in;
        end
        else if (st_r.sel_high[POS_XTAL_SEL_HI:POS_XTAL_SEL_LO] == XSEL_32K)
        begin
            st_nxt.pin = tick_32k;
        end
        else
        begin
            st_nxt.pin = st_r.div_out;
        end

        // calibrated temperature: raw plus reference, both in 1/128 degree
        st_nxt.temp_cal = temp_raw + $signed(st_r.temp_ref_calib);
    end

    // register the state; mirrors hold reset values until the copy
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.fsm <= ST_WAIT;
            st_r.sel_high <= RST_CLKOUT_BYTE;
            st_r.sel_low <= RST_CLKOUT_BYTE;
            st_r.temp_ref_calib <= RST_TEMP_REF_CALIB;
            st_r.pass <= RST_PASSCODE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // store read address walks the eight mirrored bytes
    assign nv_rd = st_nxt.copy_pend;
    assign nv_addr = OFS_CLKOUT_SEL_LOW + {4'h0, st_nxt.copy_idx};
    assign mirrors_valid = (st_r.fsm == ST_DONE);
    assign reg_rdata = st_r.rdata;
    assign temp_calibrated = st_r.temp_cal;
    assign stored_passcode = st_r.pass;
    assign clkout_cfg.osc_source_select = st_r.sel_high[POS_OSC_SRC];
    assign clkout_cfg.xtal_freq_select = st_r.sel_high[POS_XTAL_SEL_HI:POS_XTAL_SEL_LO];
    assign clkout_cfg.hf_multiplier = {st_r.sel_high[POS_HF_HI:0], st_r.sel_low};
    assign clkout_pin = st_r.pin;

    // refresh copy must start exactly after the wait count
    property p_refresh_start;
        @(posedge clk_sys) disable iff (sys_rst)
        (st_r.fsm == ST_WAIT && st_r.wait_cnt == 32'(REFRESH_CNT - 1)) |=> nv_rd ##1 (st_r.fsm == ST_COPY);
    endproperty
    a_refresh_start: assert property (p_refresh_start) else $error("refresh did not start");

    // copy finishes eight cycles after entering copy
    sequence s_enter_copy;
        $rose(st_r.fsm == ST_COPY);
    endsequence
    property p_copy_len;
        @(posedge clk_sys) disable iff (sys_rst)
        s_enter_copy |-> ##8 mirrors_valid;
    endproperty
    a_copy_len: assert property (p_copy_len) else $error("copy length wrong");

    // locked write leaves the reference unchanged
    property p_locked;
        @(posedge clk_sys) disable iff (sys_rst)
        (mirrors_valid && reg_req.wr && !write_unlocked) |=> $stable(st_r.temp_ref_calib) && $stable(st_r.sel_high);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write took effect");

    // unlocked write to reference low lands
    property p_temp_ref_calib_wr;
        @(posedge clk_sys) disable iff (sys_rst)
        (mirrors_valid && wr_ok && reg_req.addr == OFS_TEMP_REF_CALIB_LOW) |=> st_r.temp_ref_calib[7:0] == $past(reg_req.wdata);
    endproperty
    a_temp_ref_calib_wr: assert property (p_temp_ref_calib_wr) else $error("reference write lost");

    // calibrated value tracks raw plus reference
    property p_cal;
        @(posedge clk_sys) disable iff (sys_rst)
        1'b1 |=> temp_calibrated == $past(temp_raw) + $signed($past(st_r.temp_ref_calib));
    endproperty
    a_cal: assert property (p_cal) else $error("calibration mismatch");

    // synthesizer mode passes the input straight through
    property p_hf;
        @(posedge clk_sys) disable iff (sys_rst)
        (out_enable && st_r.sel_high[POS_OSC_SRC]) |=> clkout_pin == $past(hf_clock_in);
    endproperty
    a_hf: assert property (p_hf) else $error("synth output disturbed");

    // stopped low output stays static
    property p_stop;
        @(posedge clk_sys) disable iff (sys_rst)
        (low_stopped && !restart_low) |=> $stable(st_r.div_out);
    endproperty
    a_stop: assert property (p_stop) else $error("stopped output toggled");

    // restart clears the divider
    property p_restart;
        @(posedge clk_sys) disable iff (sys_rst)
        restart_low |=> st_r.div_cnt == 14'h0000 && !st_r.div_out;
    endproperty
    a_restart: assert property (p_restart) else $error("restart ignored");

    // disabled output holds low
    property p_disable;
        @(posedge clk_sys) disable iff (sys_rst)
        !out_enable |=> !clkout_pin;
    endproperty
    a_disable: assert property (p_disable) else $error("pin active while disabled");

    // writes before the copy ends are dropped, so the store value wins
    property p_early_drop;
        @(posedge clk_sys) disable iff (sys_rst)
        (st_r.fsm == ST_WAIT && reg_req.wr) |=> $stable(st_r.temp_ref_calib) && $stable(st_r.sel_high);
    endproperty
    a_early_drop: assert property (p_early_drop) else $error("write landed before copy");

    // second config byte always reads back, lock or not
    property p_read_high;
        @(posedge clk_sys) disable iff (sys_rst)
        (reg_req.addr == OFS_CLKOUT_SEL_HIGH) |=> reg_rdata == $past(st_r.sel_high);
    endproperty
    a_read_high: assert property (p_read_high) else $error("config read wrong");

    // passcode mirror never shows on the read port
    property p_pass_hidden;
        @(posedge clk_sys) disable iff (sys_rst)
        (reg_req.addr >= OFS_PASS_0 && reg_req.addr <= OFS_PASS_0 + 8'h03) |=> reg_rdata == 8'h00;
    endproperty
    a_pass_hidden: assert property (p_pass_hidden) else $error("passcode readable");

    // 32 kHz code follows the tick, stop or not
    property p_xtal32;
        @(posedge clk_sys) disable iff (sys_rst)
        (out_enable && !st_r.sel_high[POS_OSC_SRC]
            && st_r.sel_high[POS_XTAL_SEL_HI:POS_XTAL_SEL_LO] == XSEL_32K)
            |=> clkout_pin == $past(tick_32k);
    endproperty
    a_xtal32: assert property (p_xtal32) else $error("32 kHz output disturbed");

    // store reads stay inside the mirrored range
    property p_nv_range;
        @(posedge clk_sys) disable iff (sys_rst)
        nv_rd |-> (nv_addr >= OFS_CLKOUT_SEL_LOW && nv_addr <= OFS_PASS_0 + 8'h03);
    endproperty
    a_nv_range: assert property (p_nv_range) else $error("store read out of range");

    // a synced event edge restarts the low divider
    sequence s_sync_event;
        evt_edge && event_sync_enable;
    endsequence
    property p_evt_restart;
        @(posedge clk_sys) disable iff (sys_rst)
        s_sync_event |=> st_r.div_cnt == 14'h0000 && !st_r.div_out;
    endproperty
    a_evt_restart: assert property (p_evt_restart) else $error("event restart ignored");

    // once loaded, the mirrors never fall back to reset values
    property p_mirror_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        mirrors_valid |=> mirrors_valid;
    endproperty
    a_mirror_hold: assert property (p_mirror_hold) else $error("mirrors lost");

endmodule : clkout_and_temp_ref_calib_config

// file: design/clkout_cfg_pkg.sv
/*
 * constants, register layout and carrier types for the clock-output and
 * temperature-reference configuration slice.
 * assumes a byte-wide register port inside the device, a 20 MHz system clock,
 * and a non-volatile store that answers one read per cycle.
 */
// Notes on behaviour
// - second config byte: source bit7, xtal sel 6:5, multiplier high 4:0
// - source bit clear picks crystal, set picks synthesizer
// - xtal codes 32768/1024/64/1 Hz; byte ships zero
// - synth frequency is (multiplier plus one) times 8192 Hz
// - stop gates 1024/64/1 Hz only, synchronously
// - synthesizer output never takes compensation pulses
// - seconds write or synced event restarts low outputs
// - synthesizer period unaffected by seconds write or events
// - temp reference sixteen-bit, low then high byte
// - one reference step equals 0.0078125 degrees
// - reference calibrates the readable temperature result
// - after refresh time, copy reference bytes to mirrors
// - after refresh time, copy four passcode bytes too
// - config always readable, writes blockable by password
// - reference preloaded from factory, user may overwrite
// - first config byte holds multiplier low eight bits
// - output enabled by disable_n low or interrupt clock
package clkout_cfg_pkg;

    // register offsets on the internal byte port
    localparam logic [7:0] OFS_CLKOUT_SEL_LOW = 8'h0C_2;
    localparam logic [7:0] OFS_CLKOUT_SEL_HIGH = 8'h0C_3;
    localparam logic [7:0] OFS_TEMP_REF_CALIB_LOW = 8'h0C_4;
    localparam logic [7:0] OFS_TEMP_REF_CALIB_HIGH = 8'h0C_5;
    localparam logic [7:0] OFS_PASS_0 = 8'h0C_6;
    localparam int NUM_PASS_BYTES = 4;

    // field positions of the second clock-output byte
    localparam int POS_OSC_SRC = 7;
    localparam int POS_XTAL_SEL_HI = 6;
    localparam int POS_XTAL_SEL_LO = 5;
    localparam int POS_HF_HI = 4;

    // values after reset (before the store is copied)
    localparam logic [7:0] RST_CLKOUT_BYTE = 8'h00;
    localparam logic [15:0] RST_TEMP_REF_CALIB = 16'h0000;
    localparam logic [31:0] RST_PASSCODE = 32'h0000_0000;

    // crystal frequency codes
    localparam logic [1:0] XSEL_32K = 2'h0;
    localparam logic [1:0] XSEL_1024 = 2'h1;
    localparam logic [1:0] XSEL_64 = 2'h2;
    localparam logic [1:0] XSEL_1HZ = 2'h3;

    // divider half periods in 32 kHz ticks, minus one
    localparam logic [13:0] HALF_1024HZ = 14'h000F;
    localparam logic [13:0] HALF_64HZ = 14'h00FF;
    localparam logic [13:0] HALF_1HZ = 14'h3FFF;

    // timing: system clock and power-up refresh interval
    localparam int CLK_HZ = 20_000_000;
    localparam int REFRESH_MS = 66;
    localparam int REFRESH_CYCLES = (CLK_HZ / 1000) * REFRESH_MS;
    localparam int SYNTH_STEP_HZ = 8192;

    // one reference step in units of 1/128 degree; result is in same units
    localparam int TEMP_REF_CALIB_STEP_DIV = 128;

    // register access from the device's own serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // clock-output configuration as seen by the output logic
    typedef struct packed {
        logic osc_source_select;
        logic [1:0] xtal_freq_select;
        logic [12:0] hf_multiplier;
    } clkout_cfg_type;

    // refresh sequencer states
    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_COPY = 3'b010,
        ST_DONE = 3'b100
    } refresh_state_type;

endpackage : clkout_cfg_pkg

// file: design/pin_sync3.sv
/*
 * three-stage input conditioner for one asynchronous pin.
 * assumes the pin may change at any time; output updates only when the
 * second and third stages agree.
 */
`timescale 1ns/100ps
module pin_sync3
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pin_in,
    output logic level_out
);

    // whole state in one struct
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sync_state_type;

    sync_state_type st_r;
    sync_state_type st_nxt;

    // shift and qualify; s1 feeds only s2
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3)
        begin
            st_nxt.lvl = st_r.s3;
        end
    end

    // register the state
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.lvl;

endmodule : pin_sync3

// file: verif/clkout_and_temp_ref_calib_config_test.sv
/*
 * self-checking bench for the clock-output and reference slice.
 * assumes the store model answers the refresh copy; ticks come from here.
 */
`timescale 1ns/100ps
module clkout_and_temp_ref_calib_config_test;
    import clkout_cfg_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    reg_req_type reg_req = '0;
    logic [7:0] reg_rdata;
    logic write_unlocked = 1'b1;
    logic [7:0] nv_addr;
    logic nv_rd;
    logic [7:0] nv_rdata;
    logic mirrors_valid;
    logic tick_32k = 1'b0;
    logic comp_pulse = 1'b0;
    logic hf_clock_in = 1'b0;
    logic seconds_write = 1'b0;
    logic event_sync_enable = 1'b0;
    logic external_event_input = 1'b0;
    logic stop_timekeeping = 1'b0;
    logic square_wave_disable_n = 1'b0;
    logic clk_int_request = 1'b0;
    logic signed [15:0] temp_raw = 16'sh0000;
    logic signed [15:0] temp_calibrated;
    logic [31:0] stored_passcode;
    clkout_cfg_type clkout_cfg;
    logic clkout_pin;
    int num_errors = 0;
    int total_checks = 0;
    int ecnt = 0; // event pattern counter
    logic evt_on = 1'b0; // enables the event pattern
    logic [7:0] rd_val;
    int toggles;
    // pin toggles expected in 4096 cycles per crystal code
    // a 1 Hz half period is far longer than the window
    int exp_tbl [4] = '{4096, 128, 8, 0};

    clkout_and_temp_ref_calib_config #(.REFRESH_CNT(20)) u_clkout_and_temp_ref_calib_config (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .write_unlocked(write_unlocked), .nv_addr(nv_addr), .nv_rd(nv_rd),
        .nv_rdata(nv_rdata), .mirrors_valid(mirrors_valid), .tick_32k(tick_32k),
        .comp_pulse(comp_pulse), .hf_clock_in(hf_clock_in), .seconds_write(seconds_write),
        .event_sync_enable(event_sync_enable), .external_event_input(external_event_input),
        .stop_timekeeping(stop_timekeeping), .square_wave_disable_n(square_wave_disable_n),
        .clk_int_request(clk_int_request), .temp_raw(temp_raw),
        .temp_calibrated(temp_calibrated), .stored_passcode(stored_passcode),
        .clkout_cfg(clkout_cfg), .clkout_pin(clkout_pin));

    nv_store_model u_nv_store_model (
        .clk_sys(clk_sys), .nv_addr(nv_addr), .nv_rd(nv_rd), .nv_rdata(nv_rdata));

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end

    // tick one cycle high one low; hf toggles every second cycle
    always @(negedge clk_sys)
    begin
        ecnt <= ecnt + 1;
        tick_32k <= ~tick_32k;
        if (ecnt[0])
            hf_clock_in <= ~hf_clock_in;
        // event period below one 1024 Hz half period, so restarts keep it low
        external_event_input <= evt_on && (ecnt % 10 < 4);
    end

    // one compare for values, one for toggle counts
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got 0x%08h expected 0x%08h", $time, got, exp);
        end
    endtask : check_val

    // count slack covers restart phase at mode change
    task automatic check_cnt(input int got, input int exp);
        total_checks++;
        if (got < exp - 2 || got > exp + 2)
        begin
            num_errors++;
            $display("Error at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
        end
    endtask : check_cnt

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // write: one-cycle wr pulse held across one rising edge
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge clk_sys);
        reg_req.wr = 1'b0;
    endtask : reg_write

    // read: data registered at the edge after the address
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_sys);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge clk_sys);
        reg_req.rd = 1'b0;
        data = reg_rdata;
    endtask : reg_read

    task automatic count_pin(input logic [7:0] cfg, input int exp);
        logic prev;
        reg_write(OFS_CLKOUT_SEL_HIGH, cfg);
        repeat (8) @(negedge clk_sys);
        prev = clkout_pin;
        toggles = 0;
        repeat (4096)
        begin
            @(negedge clk_sys);
            if (clkout_pin !== prev)
                toggles++;
            prev = clkout_pin;
        end
        check_cnt(toggles, exp);
    endtask : count_pin

    initial
    begin
        repeat (10) @(negedge clk_sys);
        sys_rst = 1'b0;
        check_val(mirrors_valid, 32'h0000_0000);
        reg_write(OFS_TEMP_REF_CALIB_HIGH, 8'h55);
        reg_read(OFS_TEMP_REF_CALIB_HIGH, rd_val);
        check_val(rd_val, 32'h0000_0000);
        // bounded wait for the refresh copy; a timeout counts and runs on
        for (int i = 0; i < 200 && mirrors_valid !== 1'b1; i++)
            @(negedge clk_sys);
        check_val(mirrors_valid, 32'h0000_0001);
        reg_read(OFS_CLKOUT_SEL_LOW, rd_val);
        check_val(rd_val, 32'h0000_005A);
        reg_read(OFS_CLKOUT_SEL_HIGH, rd_val);
        check_val(rd_val, 32'h0000_0000);
        reg_read(OFS_TEMP_REF_CALIB_LOW, rd_val);
        check_val(rd_val, 32'h0000_0034);
        reg_read(OFS_TEMP_REF_CALIB_HIGH, rd_val);
        check_val(rd_val, 32'h0000_00F2);
        check_val(stored_passcode, 32'h4433_2211);
        reg_read(OFS_PASS_0, rd_val);
        check_val(rd_val, 32'h0000_0000);
        reg_read(8'h10, rd_val);
        check_val(rd_val, 32'h0000_0000);
        temp_raw = 16'sh0C80;
        repeat (3) @(negedge clk_sys);
        // signed result widens with its sign into the compare
        check_val(temp_calibrated, 32'hFFFF_FEB4);
        reg_write(OFS_TEMP_REF_CALIB_LOW, 8'h01);
        reg_write(OFS_TEMP_REF_CALIB_HIGH, 8'h00);
        repeat (3) @(negedge clk_sys);
        check_val(temp_calibrated, 32'h0000_0C81);
        write_unlocked = 1'b0;
        reg_write(OFS_TEMP_REF_CALIB_LOW, 8'h7F);
        reg_read(OFS_TEMP_REF_CALIB_LOW, rd_val);
        check_val(rd_val, 32'h0000_0001);
        write_unlocked = 1'b1;
        reg_write(OFS_CLKOUT_SEL_HIGH, 8'hA7);
        repeat (2) @(negedge clk_sys);
        check_val(clkout_cfg, 32'h0000_A75A);
        // every crystal code, then synth with pulses and restarts applied
        for (int i = 0; i < 4; i++)
            count_pin({1'b0, i[1:0], 5'h00}, exp_tbl[i]);
        comp_pulse = 1'b1;
        seconds_write = 1'b1;
        event_sync_enable = 1'b1;
        evt_on = 1'b1;
        count_pin(8'h80, 2048);
        count_pin(8'h20, 0);
        seconds_write = 1'b0;
        count_pin(8'h20, 0);
        evt_on = 1'b0;
        comp_pulse = 1'b0;
        stop_timekeeping = 1'b1;
        count_pin(8'h20, 0);
        count_pin(8'h00, 4096);
        count_pin(8'h80, 2048);
        stop_timekeeping = 1'b0;
        square_wave_disable_n = 1'b1;
        count_pin(8'h00, 0);
        check_val(clkout_pin, 32'h0000_0000);
        clk_int_request = 1'b1;
        count_pin(8'h00, 4096);
        tally_and_finish();
    end
endmodule : clkout_and_temp_ref_calib_config_test

// file: verif/nv_store_model.sv
/*
 * behavioural non-volatile store behind the configuration slice.
 * assumes one read per nv_rd pulse, data due on the following cycle.
 */
`timescale 1ns/100ps
module nv_store_model
(
    input wire logic clk_sys,
    input wire logic [7:0] nv_addr,
    input wire logic nv_rd,
    output logic [7:0] nv_rdata
);
    // stored bytes for c2..c9; temp_ref_calib plays the factory-calibrated value
    logic [7:0] mem [0:7];
    logic [7:0] out_r = 8'h00; // last value driven
    initial
    begin
        mem = '{8'h5A, 8'h00, 8'h34, 8'hF2, 8'h11, 8'h22, 8'h33, 8'h44};
    end
    // answer one cycle after the pulse; otherwise flip so stale data never matches
    always_ff @(posedge clk_sys)
    begin
        if (nv_rd && nv_addr >= 8'hC2 && nv_addr <= 8'hC9)
            out_r <= mem[nv_addr - 8'hC2];
        else
            out_r <= ~out_r;
    end
    assign nv_rdata = out_r;
endmodule : nv_store_model
